// ===== include/xarp_mem_if.sv
interface xarp_mem_if #(
    parameter int AW = 1,
    parameter int DW = 14
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : xarp_mem_if

// ===== include/xarp_pkg.sv
package xarp_pkg;
    // analog field widths
    localparam int VOD_W    = 3;
    localparam int PRE_W    = 5;
    localparam int EQ_W     = 4;
    localparam int DCG_W    = 2;
    localparam int FIELD_W  = VOD_W + PRE_W + EQ_W + DCG_W;
    // packed field positions inside one channel word
    localparam int VOD_LSB  = 0;
    localparam int PRE_LSB  = VOD_LSB + VOD_W;
    localparam int EQ_LSB   = PRE_LSB + PRE_W;
    localparam int DCG_LSB  = EQ_LSB + EQ_W;
    // reset values
    localparam logic [VOD_W-1:0] VOD_RST = 3'h0;
    localparam logic [PRE_W-1:0] PRE_RST = 5'h00;
    localparam logic [EQ_W-1:0]  EQ_RST  = 4'h0;
    localparam logic [DCG_W-1:0] DCG_RST = 2'h0;
    // dc gain codes
    localparam logic [DCG_W-1:0] DCG_0DB = 2'h0;
    localparam logic [DCG_W-1:0] DCG_3DB = 2'h1;
    localparam logic [DCG_W-1:0] DCG_6DB = 2'h2;
    // mode selector
    localparam int MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_SEL_PMA  = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SEL_CHAN = 3'h1;
    typedef enum logic {
        XARP_MODE_PMA,
        XARP_MODE_CHAN
    } xarp_mode_t;
endpackage : xarp_pkg

// ===== src/xarp_analog_ports.sv
// Contract
// - optional dc gain write input updates a channel's analog dc gain
// - shared or logical-address option: dc gain input is one 2-bit field
// - otherwise one 2-bit dc gain field per channel, concatenated
// - drive-level read-back shows value last written to that channel
// - equalization read-back shows current setting held for channel
// - dc gain read-back shows current setting held for channel
// - read-back widths scale per channel, collapse to one when shared or logical-address
// - selector 000 means pma analog-control mode, the default
// - selector 001 means channel reconfiguration; no other values
// - selector exists only with several modes, else mode is fixed; mode_sel_in is then ignored, but reset still loads pma mode
// - equalization write and read-back fields are 4 bits wide
module xarp_analog_ports #(
    parameter int NUM_CH      = 4,
    parameter bit SHARED_CTRL = 1'b0,
    parameter bit LOGICAL_ADR = 1'b0,
    parameter bit MULTI_MODE  = 1'b1,
    parameter bit FIXED_CHAN  = 1'b0,
    parameter int CH_AW       = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
    parameter int NF          = (SHARED_CTRL || LOGICAL_ADR) ? 1 : NUM_CH
) (
    // clock and reset
    input  wire logic                               clk_in,
    input  wire logic                               sys_rst_in,
    // mode selection
    input  wire logic [xarp_pkg::MODE_W-1:0]        mode_sel_in,
    output logic                                    mode_chan_out,
    output logic                                    mode_bad_out,
    // write side
    input  wire logic                               wr_en_in,
    input  wire logic [CH_AW-1:0]                   log_ch_in,
    input  wire logic [NF*xarp_pkg::VOD_W-1:0]      vod_in,
    input  wire logic [NF*xarp_pkg::PRE_W-1:0]      preemp_in,
    input  wire logic [NF*xarp_pkg::EQ_W-1:0]       eq_in,
    input  wire logic [NF*xarp_pkg::DCG_W-1:0]      dcgain_in,
    // analog settings applied to channels
    output logic [NUM_CH*xarp_pkg::FIELD_W-1:0]     ch_setting_out,
    // read-back
    output logic [NF*xarp_pkg::VOD_W-1:0]           vod_rb_out,
    output logic [NF*xarp_pkg::PRE_W-1:0]           preemp_rb_out,
    output logic [NF*xarp_pkg::EQ_W-1:0]            eq_rb_out,
    output logic [NF*xarp_pkg::DCG_W-1:0]           dcgain_rb_out,
    output logic                                    dcgain_bad_out
);
    localparam int FW = xarp_pkg::FIELD_W;
    localparam logic [FW-1:0] RST_WORD = {xarp_pkg::DCG_RST,
        xarp_pkg::EQ_RST, xarp_pkg::PRE_RST, xarp_pkg::VOD_RST};

    function automatic logic [FW-1:0] pack_word(
        input logic [xarp_pkg::VOD_W-1:0] v,
        input logic [xarp_pkg::PRE_W-1:0] p,
        input logic [xarp_pkg::EQ_W-1:0]  e,
        input logic [xarp_pkg::DCG_W-1:0] d
    );
        pack_word = {d, e, p, v};
    endfunction : pack_word

    xarp_pkg::xarp_mode_t mode_ff;
    xarp_pkg::xarp_mode_t nxt_mode;
    logic                 bad_ff;
    logic                 nxt_bad;
    logic [FW-1:0]        chan_ff [NUM_CH];
    logic [FW-1:0]        nxt_chan [NUM_CH];
    logic [NF*FW-1:0]     wr_word;
    logic                 dcg_bad;
    logic                 dcg_bad_ff;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_bad  = 1'b0;
        if (!MULTI_MODE) begin
            nxt_mode = FIXED_CHAN ? xarp_pkg::XARP_MODE_CHAN
                                  : xarp_pkg::XARP_MODE_PMA;
        end else begin
            case (mode_sel_in)
                xarp_pkg::MODE_SEL_PMA: begin
                    nxt_mode = xarp_pkg::XARP_MODE_PMA;
                end
                xarp_pkg::MODE_SEL_CHAN: begin
                    nxt_mode = xarp_pkg::XARP_MODE_CHAN;
                end
                default: begin
                    // illegal code: keep mode, flag it
                    nxt_bad = 1'b1;
                end
            endcase
        end
    end

    // pack incoming fields per write slot
    always_comb begin
        wr_word = '0;
        dcg_bad = 1'b0;
        for (int f = 0; f < NF; f++) begin
            wr_word[f*FW +: FW] = pack_word(
                vod_in[f*xarp_pkg::VOD_W +: xarp_pkg::VOD_W],
                preemp_in[f*xarp_pkg::PRE_W +: xarp_pkg::PRE_W],
                eq_in[f*xarp_pkg::EQ_W +: xarp_pkg::EQ_W],
                dcgain_in[f*xarp_pkg::DCG_W +: xarp_pkg::DCG_W]);
            if (wr_en_in && dcgain_in[f*xarp_pkg::DCG_W +: xarp_pkg::DCG_W]
                    > xarp_pkg::DCG_6DB) begin
                dcg_bad = 1'b1;
            end
        end
    end

    // settings written only in pma mode; illegal dc gain is not stored
    always_comb begin
        nxt_chan = chan_ff;
        if (wr_en_in && !dcg_bad && mode_ff == xarp_pkg::XARP_MODE_PMA) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (LOGICAL_ADR) begin
                    if (log_ch_in == CH_AW'(c)) begin
                        nxt_chan[c] = wr_word[FW-1:0];
                    end
                end else if (SHARED_CTRL) begin
                    nxt_chan[c] = wr_word[FW-1:0];
                end else begin
                    nxt_chan[c] = wr_word[c*FW +: FW];
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_ff    <= xarp_pkg::XARP_MODE_PMA;
            bad_ff     <= 1'b0;
            dcg_bad_ff <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                chan_ff[c] <= RST_WORD;
            end
        end else begin
            mode_ff    <= nxt_mode;
            bad_ff     <= nxt_bad;
            dcg_bad_ff <= dcg_bad;
            chan_ff    <= nxt_chan;
        end
    end

    // logical-address read-back through registered memory copy, addressed by logical channel
    xarp_mem_if #(.AW(CH_AW), .DW(FW)) rb_if ();

    assign rb_if.wr_en   = wr_en_in && !dcg_bad
                           && mode_ff == xarp_pkg::XARP_MODE_PMA;
    assign rb_if.wr_addr = log_ch_in;
    assign rb_if.wr_data = wr_word[FW-1:0];
    assign rb_if.rd_addr = log_ch_in;

    xarp_setting_mem #(
        .DEPTH    (NUM_CH),
        .AW       (CH_AW),
        .DW       (FW),
        .RST_WORD (RST_WORD)
    ) u_rb_mem (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .port       (rb_if.mem)
    );

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ch_setting_out[c*FW +: FW] = chan_ff[c];
        end
    end

    // per-channel or collapsed read-back fields
    always_comb begin
        logic [FW-1:0] w;
        w = '0;
        for (int f = 0; f < NF; f++) begin
            if (LOGICAL_ADR) begin
                w = rb_if.rd_data;
            end else begin
                w = chan_ff[f];
            end
            vod_rb_out[f*xarp_pkg::VOD_W +: xarp_pkg::VOD_W] =
                w[xarp_pkg::VOD_LSB +: xarp_pkg::VOD_W];
            preemp_rb_out[f*xarp_pkg::PRE_W +: xarp_pkg::PRE_W] =
                w[xarp_pkg::PRE_LSB +: xarp_pkg::PRE_W];
            eq_rb_out[f*xarp_pkg::EQ_W +: xarp_pkg::EQ_W] =
                w[xarp_pkg::EQ_LSB +: xarp_pkg::EQ_W];
            dcgain_rb_out[f*xarp_pkg::DCG_W +: xarp_pkg::DCG_W] =
                w[xarp_pkg::DCG_LSB +: xarp_pkg::DCG_W];
        end
    end

    assign mode_chan_out  = (mode_ff == xarp_pkg::XARP_MODE_CHAN);
    assign mode_bad_out   = bad_ff;
    assign dcgain_bad_out = dcg_bad_ff;
endmodule : xarp_analog_ports

// ===== src/xarp_setting_mem.sv
module xarp_setting_mem #(
    parameter int DEPTH = 4,
    parameter int AW    = 2,
    parameter int DW    = 14,
    parameter logic [DW-1:0] RST_WORD = '0
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // access port
    xarp_mem_if.mem   port
);
    logic [DW-1:0] mem_ff [DEPTH];
    logic [DW-1:0] nxt_mem [DEPTH];
    logic [DW-1:0] rd_ff;
    logic [DW-1:0] nxt_rd;

    always_comb begin
        nxt_mem = mem_ff;
        if (port.wr_en) begin
            nxt_mem[port.wr_addr] = port.wr_data;
        end
        // new data visible once the write is stored
        nxt_rd = nxt_mem[port.rd_addr];
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= RST_WORD;
            end
            rd_ff <= RST_WORD;
        end else begin
            mem_ff <= nxt_mem;
            rd_ff  <= nxt_rd;
        end
    end

    assign port.rd_data = rd_ff;
endmodule : xarp_setting_mem

// ===== testbench/xarp_analog_ports_bench.sv
module xarp_analog_ports_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 4;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        wr_en_in = 1'b0;
    logic        chan = 1'b0;
    logic        exp_chan = 1'b0;
    logic [2:0]  ill = 3'h0;
    logic [1:0]  log_ch_in = 2'h0;
    logic [11:0] vod_in = '0;
    logic [19:0] preemp_in = '0;
    logic [15:0] eq_in = '0;
    logic [7:0]  pick = '0;
    logic [7:0]  force_bad = '0;
    logic [7:0]  dcg_ok, dcgain_in, dcgain_rb_out;
    logic [2:0]  sel_ok, mode_sel_in;
    logic        mode_chan_out, mode_bad_out, dcgain_bad_out;
    logic [55:0] ch_setting_out;
    logic [11:0] vod_rb_out;
    logic [19:0] preemp_rb_out;
    logic [15:0] eq_rb_out;
    int          err_total = 0;
    int          comparisons = 0;
    int          m_vod[N], m_pre[N], m_eq[N], m_dcg[N];
    always #20 clk_in = ~clk_in;
    assign dcgain_in   = dcg_ok | force_bad;
    assign mode_sel_in = (ill > 3'h1) ? ill : sel_ok;
    xarp_analog_ports i_xarp_analog_ports (.*);
    xarp_user_model i_xarp_user_model (.pick_in(pick), .chan_in(chan),
        .dcgain_out(dcg_ok), .mode_sel_out(sel_ok));
    task automatic check_val(input string nm, input logic [63:0] seen,
                             input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check_val
    task automatic check_rb();
        logic [63:0] v, p, e, d, s;
        {v, p, e, d, s} = '0;
        for (int i = 0; i < N; i++) begin
            v[3*i +: 3] = m_vod[i][2:0];
            p[5*i +: 5] = m_pre[i][4:0];
            e[4*i +: 4] = m_eq[i][3:0];
            d[2*i +: 2] = m_dcg[i][1:0];
            s[14*i +: 14] = {d[2*i +: 2], e[4*i +: 4],
                             p[5*i +: 5], v[3*i +: 3]};
        end
        check_val("vod_rb", vod_rb_out, v);
        check_val("preemp_rb", preemp_rb_out, p);
        check_val("eq_rb", eq_rb_out, e);
        check_val("dcgain_rb", dcgain_rb_out, d);
        check_val("setting", ch_setting_out, s);
    endtask : check_rb
    task automatic step(input bit en);
        bit take, bd, bm, nchan;
        wr_en_in = en;
        vod_in = $urandom;
        preemp_in = $urandom;
        eq_in = $urandom;
        pick = $urandom;
        bd = en && force_bad != 8'h00;
        take = en && !exp_chan && !bd;
        bm = ill > 3'h1;
        nchan = bm ? exp_chan : chan;
        @(posedge clk_in);
        #1;
        exp_chan = nchan;
        for (int i = 0; i < N && take; i++) begin
            m_vod[i] = vod_in[3*i +: 3];
            m_pre[i] = preemp_in[5*i +: 5];
            m_eq[i] = eq_in[4*i +: 4];
            m_dcg[i] = dcgain_in[2*i +: 2];
        end
        check_rb();
        check_val("mode_chan", mode_chan_out, exp_chan);
        check_val("mode_bad", mode_bad_out, bm);
        check_val("dcg_bad", dcgain_bad_out, bd);
    endtask : step
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        void'($urandom(32'hc7c0));
        for (int i = 0; i < N; i++) begin
            {m_vod[i], m_pre[i], m_eq[i], m_dcg[i]} = '0;
        end
        repeat (5) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        check_rb();
        repeat (40) step($urandom_range(0, 1));
        // a refused write must leave every channel untouched
        force_bad = 8'h0c;
        step(1'b1);
        force_bad = 8'h00;
        chan = 1'b1;
        repeat (2) step(1'b1);
        for (int c = 2; c < 8; c++) begin
            ill = c[2:0];
            step(1'b1);
        end
        ill = 3'h0;
        chan = 1'b0;
        repeat (3) step(1'b1);
        give_verdict();
    end
endmodule : xarp_analog_ports_bench

// ===== testbench/xarp_analog_ports_monitor.sv
module xarp_analog_ports_monitor #(
    parameter int NUM_CH = 4,
    parameter int NF     = 4,
    parameter int CH_AW  = 2
) (
    // clock, reset and mode
    input wire logic                 clk_in,
    input wire logic                 sys_rst_in,
    input wire logic [2:0]           mode_sel_in,
    input wire logic                 mode_chan_out,
    input wire logic                 mode_bad_out,
    // write side
    input wire logic                 wr_en_in,
    input wire logic [CH_AW-1:0]     log_ch_in,
    input wire logic [NF*3-1:0]      vod_in,
    input wire logic [NF*5-1:0]      preemp_in,
    input wire logic [NF*4-1:0]      eq_in,
    input wire logic [NF*2-1:0]      dcgain_in,
    // settings and read-back
    input wire logic [NUM_CH*14-1:0] ch_setting_out,
    input wire logic [NF*3-1:0]      vod_rb_out,
    input wire logic [NF*5-1:0]      preemp_rb_out,
    input wire logic [NF*4-1:0]      eq_rb_out,
    input wire logic [NF*2-1:0]      dcgain_rb_out,
    input wire logic                 dcgain_bad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic        bad_code;
    logic        take;
    logic [13:0] word0;
    always_comb begin
        bad_code = 1'b0;
        for (int i = 0; i < NF; i++) begin
            bad_code = bad_code | (dcgain_in[2*i +: 2] == 2'h3);
        end
    end
    assign take  = wr_en_in && !mode_chan_out && !bad_code;
    assign word0 = {dcgain_in[1:0], eq_in[3:0], preemp_in[4:0], vod_in[2:0]};
    mode_pma_a: assert property (mode_sel_in == 3'h0 |=> !mode_chan_out)
        else $error("selector 000 did not give pma mode");
    mode_chan_a: assert property (mode_sel_in == 3'h1 |=> mode_chan_out)
        else $error("selector 001 did not give channel mode");
    mode_keep_a: assert property (mode_sel_in > 3'h1 |=>
        mode_bad_out && mode_chan_out == $past(mode_chan_out))
        else $error("illegal selector changed mode or no flag");
    dcg_bad_a: assert property (wr_en_in && !mode_chan_out && bad_code
        |=> dcgain_bad_out && $stable(dcgain_rb_out))
        else $error("dc gain 11 write not refused");
    rb_take_a: assert property (take |=>
        dcgain_rb_out == $past(dcgain_in) && eq_rb_out == $past(eq_in))
        else $error("dc gain or eq read-back wrong after write");
    rb_tx_a: assert property (take |=> vod_rb_out == $past(vod_in)
        && preemp_rb_out == $past(preemp_in))
        else $error("vod or pre-emphasis read-back wrong");
    rb_hold_a: assert property (!take |=> $stable(vod_rb_out)
        && $stable(preemp_rb_out) && $stable(eq_rb_out)
        && $stable(dcgain_rb_out))
        else $error("read-back moved without accepted write");
    chan_block_a: assert property (wr_en_in && mode_chan_out
        |=> $stable(ch_setting_out))
        else $error("write applied in channel mode");
    setting_a: assert property (take |=>
        ch_setting_out[13:0] == $past(word0))
        else $error("channel 0 setting word wrong");
    cover property (take ##1 take);
    cover property (mode_bad_out);
    cover property (dcgain_bad_out);
    cover property (mode_chan_out ##1 !mode_chan_out);
endmodule : xarp_analog_ports_monitor
bind xarp_analog_ports xarp_analog_ports_monitor #(
    .NUM_CH(NUM_CH), .NF(NF), .CH_AW(CH_AW)
) i_xarp_analog_ports_monitor (.*);

// ===== testbench/xarp_user_model.sv
module xarp_user_model #(
    parameter int NF = 4
) (
    // one setting index per channel, and mode wish
    input  wire logic [NF*2-1:0] pick_in,
    input  wire logic            chan_in,
    // codes toward the design
    output logic      [NF*2-1:0] dcgain_out,
    output logic      [2:0]      mode_sel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int i = 0; i < NF; i++) begin
            // index 3 folds onto 0 dB so code 11 never leaves here
            dcgain_out[2*i +: 2] = &pick_in[2*i +: 2] ? 2'h0
                : pick_in[2*i +: 2];
        end
    end
    assign mode_sel_out = chan_in ? 3'h1 : 3'h0;
endmodule : xarp_user_model
